//--- dss_debug_sequencer_status.sv
// Strobed register access and the placing of the registers were decided locally.
`timescale 1ns/1ns
// Function
// - Trace-full sets once 64 or more lines were captured since the last arming and the session is still armed on the next edge.
// - While trace-full is set all 64 lines are valid regardless of the line count.
// - Writing one to the arm bit clears trace-full in status bit 7.
// - Only power-on reset and an arm write clear trace-full; the system reset leaves it alone.
// - Trace-full is also bit 7 of the trace line count register.
// - During a session the state field in bits 2-0 follows every new sequencer state.
// - A software disarm keeps the last state reached in the state field.
// - An internal end event returns the sequencer to disarmed and clears the field to 000.
// - Arming enters state one and forces the field to 001.
// - Field codes: 000 disarmed, 001-011 states one to three, 100 final, rest reserved.
module dss_debug_sequencer_status (
  // Clock and resets
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic sys_reset_in,
  // Register port
  input wire logic [3:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [7:0] rdata_out,
  // Trace and sequencer events
  input wire logic capture_in,
  input wire logic advance_in,
  input wire logic [2:0] next_state_in,
  input wire logic end_event_in,
  // Status and interrupt
  output logic armed_out,
  output logic [2:0] state_out,
  output logic trace_full_out,
  output logic irq_out
);

  // Each field has its own small next-value process below;
  // one assembly process gathers them into the state copy,
  // and one clocked process registers that copy.
  // Trace-full lives in the same state as the rest; only the
  // assembly step treats it apart, for the system reset.
  // Trace-full waits on the line total's register, so it sets one edge after the line total reaches 64 if the session is still armed then.

  // Register request gathered into one carrier
  dss_pkg::dss_bus_t bus;

  // Whole module state
  dss_pkg::dss_regs_t state_r;
  // Next value of the whole state
  dss_pkg::dss_regs_t state_nxt;

  // Write of one to the arm bit
  logic arm_wr;
  // Write of zero to the arm bit
  logic disarm_wr;
  // Write to the interrupt clear word
  logic clear_wr;
  // Write to the interrupt enable word
  logic enable_wr;

  // Internal end event inside a session
  logic end_hit;
  // Accepted move to a new sequencer state
  logic adv_hit;
  // Trace line captured inside a session
  logic capture_hit;

  // Next trace-full value
  logic full_next;
  // Trace-full rising this cycle
  logic full_hit;
  // Next session flag
  logic armed_next;
  // Next state field
  dss_pkg::dss_state_t code_next;
  // Next saturating line total
  logic [6:0] lines_next;
  // Next visible line count
  logic [5:0] count_next;
  // Next interrupt enable word
  logic [dss_pkg::IRQ_W-1:0] enable_next;

  // Interrupt events this cycle
  logic [dss_pkg::IRQ_W-1:0] irq_set;
  // Interrupt bits software clears this cycle
  logic [dss_pkg::IRQ_W-1:0] irq_clr;
  // Next sticky interrupt status
  logic [dss_pkg::IRQ_W-1:0] irq_next;

  // Word selected by the read address
  logic [7:0] rd_word;
  // Read data for the next cycle
  logic [7:0] rdata_next;

  // Valid target codes; reserved codes are never entered
  function automatic logic dss_valid(input logic [2:0] code);
    dss_valid = (code <= dss_pkg::DSS_FINAL);
  endfunction

  // One write strobe landing on one register word
  function automatic logic dss_wr_hit(input dss_pkg::dss_bus_t req,
                                      input logic [3:0] where);
    dss_wr_hit = req.wr && (req.addr == where);
  endfunction

  // Read multiplexer; unmapped and write-only words read zero
  function automatic logic [7:0] dss_read(input dss_pkg::dss_regs_t regs,
                                          input logic [3:0] where);
    case (where)
      // Trace-full over the state field
      dss_pkg::ADDR_STATUS: begin
        dss_read = {regs.full, dss_pkg::PAD4, regs.state};
      end
      // Session flag in the arm position
      dss_pkg::ADDR_CONTROL: begin
        dss_read = {regs.armed, dss_pkg::PAD7};
      end
      // Trace-full doubles as the count's top bit
      dss_pkg::ADDR_COUNT: begin
        dss_read = {regs.full, dss_pkg::PAD1, regs.count};
      end
      // Sticky interrupt bits
      dss_pkg::ADDR_IRQ_STATUS: begin
        dss_read = {dss_pkg::PAD5, regs.irq_status};
      end
      // Enable bits read back as written
      dss_pkg::ADDR_IRQ_ENABLE: begin
        dss_read = {dss_pkg::PAD5, regs.irq_enable};
      end
      // Clear word and holes read zero
      default: begin
        dss_read = dss_pkg::ZERO8;
      end
    endcase
  endfunction

  // Pins taken as synchronous, so no input flops and no added latency
  assign bus = '{addr: addr_in, wdata: wdata_in, wr: wr_in, rd: rd_in};

  // Control word: bit 7 high arms, low disarms
  assign arm_wr = dss_wr_hit(bus, dss_pkg::ADDR_CONTROL) && bus.wdata[dss_pkg::ARM_BIT];
  assign disarm_wr = dss_wr_hit(bus, dss_pkg::ADDR_CONTROL) && !bus.wdata[dss_pkg::ARM_BIT];

  // Interrupt clear and enable words
  assign clear_wr = dss_wr_hit(bus, dss_pkg::ADDR_IRQ_CLEAR);
  assign enable_wr = dss_wr_hit(bus, dss_pkg::ADDR_IRQ_ENABLE);

  // Status, count and irq status have no write path at all,
  // so a stray write there cannot disturb them

  // Captures only count inside a session;
  // a capture while disarmed is simply dropped
  assign capture_hit = state_r.armed && capture_in;

  // End event wins over an advance in the same cycle,
  // so the field reads 000 even if an advance was pending
  assign end_hit = state_r.armed && end_event_in;

  // Advance ignored for code 000, reserved codes or the same state;
  // which state comes next is the comparator logic's choice,
  // and a jump straight to the final state is legal
  assign adv_hit = state_r.armed && advance_in && !end_event_in &&
                   dss_valid(next_state_in) &&
                   (next_state_in != dss_pkg::DSS_DISARMED) &&
                   (next_state_in != state_r.state);

  // Trace-full: sticky between arming and a full buffer
  always_comb begin
    full_next = state_r.full;
    // Arm wins over a same-cycle set: a new session starts empty
    if (arm_wr) begin
      full_next = 1'h0;
    end else if (state_r.armed && (state_r.lines >= dss_pkg::TRACE_LINES)) begin
      // Sets only while armed; the line total stops moving once disarmed
      full_next = 1'h1;
    end
  end

  // Rising full raises its interrupt event
  assign full_hit = full_next && !state_r.full;

  // Session flag; a re-arm while armed simply restarts
  always_comb begin
    armed_next = state_r.armed;
    if (end_hit || disarm_wr) begin
      armed_next = 1'h0;
    end
    // Arm last, so an arm beside an end event still arms
    if (arm_wr) begin
      armed_next = 1'h1;
    end
  end

  // State field; a software disarm leaves it where it was
  always_comb begin
    code_next = state_r.state;
    // End before advance; arm overrides both
    if (end_hit) begin
      code_next = dss_pkg::DSS_DISARMED;
    end else if (adv_hit) begin
      code_next = dss_pkg::dss_state_t'(next_state_in);
    end
    if (arm_wr) begin
      code_next = dss_pkg::DSS_STATE1;
    end
  end

  // Line total saturates at the buffer depth so it cannot wrap to zero
  always_comb begin
    lines_next = state_r.lines;
    // The depth check keeps further captures from pushing past the top
    if (capture_hit && (state_r.lines < dss_pkg::TRACE_LINES)) begin
      lines_next = state_r.lines + dss_pkg::LINES_ONE;
    end
    // Arm clears last, so a capture in the arm cycle is not counted
    if (arm_wr) begin
      lines_next = dss_pkg::LINES_ZERO;
    end
  end

  // Visible count wraps; trace-full tells software that it did.
  // Software wanting the true total must read trace-full too.
  always_comb begin
    count_next = state_r.count;
    if (capture_hit) begin
      count_next = state_r.count + dss_pkg::COUNT_ONE;
    end
    // Same arm priority as the line total
    if (arm_wr) begin
      count_next = dss_pkg::COUNT_ZERO;
    end
  end

  // Interrupt events in their status positions
  always_comb begin
    // Start from no event
    irq_set = dss_pkg::IRQ_ZERO;
    irq_set[dss_pkg::IRQ_FULL_BIT] = full_hit;
    irq_set[dss_pkg::IRQ_END_BIT] = end_hit;
    irq_set[dss_pkg::IRQ_STATE_BIT] = adv_hit;
  end

  // Write-one-to-clear mask
  assign irq_clr = clear_wr ? bus.wdata[dss_pkg::IRQ_W-1:0] : dss_pkg::IRQ_ZERO;

  // Per-bit sticky status; a set in the clear cycle wins so no event is lost.
  // Kept bit-wise so a new event source is one more position.
  genvar gi;
  generate
    for (gi = 0; gi < dss_pkg::IRQ_W; gi++) begin : g_irq
      assign irq_next[gi] = irq_set[gi] | (state_r.irq_status[gi] & ~irq_clr[gi]);
    end
  endgenerate

  // Enable word written whole
  always_comb begin
    enable_next = state_r.irq_enable;
    // Enable bits are not touched by arming
    if (enable_wr) begin
      enable_next = bus.wdata[dss_pkg::IRQ_W-1:0];
    end
  end

  // Read data stand only in the cycle after the strobe, zero otherwise
  assign rd_word = dss_read(state_r, bus.addr);
  assign rdata_next = bus.rd ? rd_word : dss_pkg::ZERO8;

  // Next state assembled from the field processes
  always_comb begin
    state_nxt = state_r;
    state_nxt.full = full_next;
    state_nxt.armed = armed_next;
    state_nxt.state = code_next;
    state_nxt.lines = lines_next;
    state_nxt.count = count_next;
    state_nxt.irq_status = irq_next;
    state_nxt.irq_enable = enable_next;
    state_nxt.rdata = rdata_next;
    // A system reset zeroes all but trace-full, so a full buffer survives it
    if (sys_reset_in) begin
      state_nxt = '0;
      state_nxt.full = state_r.full;
    end
  end

  // Power-on reset is the only asynchronous clear of the whole state
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Outputs straight from the state flops
  assign rdata_out = state_r.rdata;
  assign armed_out = state_r.armed;
  assign state_out = state_r.state;
  assign trace_full_out = state_r.full;

  // Level interrupt from enabled sticky bits;
  // combinational from flops, so it drops the edge after a clear
  assign irq_out = |(state_r.irq_status & state_r.irq_enable);

endmodule

//--- dss_pkg.sv
package dss_pkg;
  // Register word offsets on the plain register port
  localparam logic [3:0] ADDR_STATUS = 4'h0;
  localparam logic [3:0] ADDR_CONTROL = 4'h1;
  localparam logic [3:0] ADDR_COUNT = 4'h2;
  localparam logic [3:0] ADDR_IRQ_STATUS = 4'h3;
  localparam logic [3:0] ADDR_IRQ_CLEAR = 4'h4;
  localparam logic [3:0] ADDR_IRQ_ENABLE = 4'h5;
  // Field positions
  localparam int FULL_BIT = 7;
  localparam int ARM_BIT = 7;
  localparam int IRQ_FULL_BIT = 0;
  localparam int IRQ_END_BIT = 1;
  localparam int IRQ_STATE_BIT = 2;
  // Buffer geometry, the zero read word and the interrupt width
  localparam logic [6:0] TRACE_LINES = 7'h40;
  localparam logic [7:0] ZERO8 = 8'h00;
  localparam logic [2:0] IRQ_ZERO = 3'h0;
  localparam int IRQ_W = 3;
  // Counter steps and clears
  localparam logic [6:0] LINES_ONE = 7'h01;
  localparam logic [6:0] LINES_ZERO = 7'h00;
  localparam logic [5:0] COUNT_ONE = 6'h01;
  localparam logic [5:0] COUNT_ZERO = 6'h00;
  // Unused bits of the read words
  localparam logic PAD1 = 1'h0;
  localparam logic [3:0] PAD4 = 4'h0;
  localparam logic [4:0] PAD5 = 5'h00;
  localparam logic [6:0] PAD7 = 7'h00;

  // Sequencer state encoding
  typedef enum logic [2:0] {
    DSS_DISARMED = 3'b000,
    DSS_STATE1 = 3'b001,
    DSS_STATE2 = 3'b010,
    DSS_STATE3 = 3'b011,
    DSS_FINAL = 3'b100
  } dss_state_t;

  // Register bus request
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } dss_bus_t;

  // Whole module state
  typedef struct packed {
    logic full;
    logic armed;
    dss_state_t state;
    logic [6:0] lines;
    logic [5:0] count;
    logic [2:0] irq_status;
    logic [2:0] irq_enable;
    logic [7:0] rdata;
  } dss_regs_t;
endpackage

//--- dss_chk.sv
`timescale 1ns/1ns
module dss_chk (
  // Clock, resets and register port
  input wire logic clk_in, resetn_in, sys_reset_in, wr_in, rd_in,
  input wire logic [3:0] addr_in,
  input wire logic [7:0] wdata_in, rdata_out,
  // Events and status
  input wire logic capture_in, advance_in, end_event_in, armed_out, trace_full_out,
  input wire logic [2:0] next_state_in, state_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  // Control write; calm excludes events that would race a write
  wire ctl = wr_in && addr_in == 4'h1;
  wire calm = !sys_reset_in && !end_event_in && !advance_in;
  arm_entry_a: assert property (ctl && wdata_in[7] && calm
    |=> armed_out && state_out == 3'h1 && !trace_full_out) else $error("arm");
  code_legal_a: assert property (state_out <= 3'h4) else $error("code");
  end_clear_a: assert property (armed_out && end_event_in && !ctl && !sys_reset_in
    |=> state_out == 3'h0 && !armed_out) else $error("end");
  disarm_keep_a: assert property (ctl && !wdata_in[7] && calm
    |=> !armed_out && $stable(state_out)) else $error("disarm");
  adv_follow_a: assert property (armed_out && advance_in && next_state_in inside {[1:4]}
    && !end_event_in && !ctl && !sys_reset_in |=> state_out == $past(next_state_in))
    else $error("advance");
  no_write_a: assert property (wr_in && addr_in == 4'h0 && calm && !capture_in
    |=> $stable(state_out) && $stable(trace_full_out)) else $error("write");
  sys_keep_a: assert property (sys_reset_in
    |=> trace_full_out == $past(trace_full_out) && state_out == 3'h0) else $error("sys");
  status_rd_a: assert property (rd_in && addr_in == 4'h0 && !sys_reset_in
    |=> rdata_out == {$past(trace_full_out), 4'h0, $past(state_out)}) else $error("read");
endmodule
bind dss_debug_sequencer_status dss_chk u_chk (.*);

//--- tb_top.sv
`timescale 1ns/1ns
module tb_top;
  logic clk_in = 0, resetn_in = 0, sys_reset_in = 0, wr_in = 0, rd_in = 0;
  logic capture_in = 0, advance_in = 0, end_event_in = 0;
  logic [3:0] addr_in = 4'h0;
  logic [7:0] wdata_in = 8'h00;
  logic [2:0] next_state_in = 3'h0;
  logic [7:0] rdata_out;
  logic armed_out, trace_full_out, irq_out;
  logic [2:0] state_out;
  int n_errors = 0;
  int compares = 0;
  always #50 clk_in = ~clk_in;
  dss_debug_sequencer_status u_dut (.*);
  task automatic chk(input string nm, input logic [7:0] exp, got);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask
  // Every access ends on an idle edge so strobes never re-assert in one step
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
    @(posedge clk_in);
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1 chk($sformatf("reg%h", a), exp, rdata_out);
    @(posedge clk_in);
  endtask
  task automatic adv(input logic [2:0] s);
    next_state_in <= s;
    advance_in <= 1'b1;
    @(posedge clk_in);
    advance_in <= 1'b0;
    @(posedge clk_in);
  endtask
  task automatic final_report;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Watchdog against a hang
  initial begin
    #100000;
    n_errors++;
    final_report;
  end
  initial begin
    repeat (5) @(posedge clk_in);
    resetn_in <= 1'b1;
    @(posedge clk_in);
    rd(4'h0, 8'h00);
    wr(4'h5, 8'h01);
    rd(4'h5, 8'h01);
    wr(4'h1, 8'h80);
    rd(4'h0, 8'h01);
    rd(4'h1, 8'h80);
    // Code 5 is reserved, so the final state must stay
    for (int s = 2; s <= 5; s++) begin
      adv(s[2:0]);
      rd(4'h0, (s == 5) ? 8'h04 : 8'(s));
    end
    chk("irq", 8'h00, {7'h0, irq_out});
    wr(4'h0, 8'hff);
    rd(4'h0, 8'h04);
    wr(4'h1, 8'h00);
    rd(4'h0, 8'h04);
    chk("armed", 8'h00, {7'h0, armed_out});
    wr(4'h1, 8'h80);
    repeat (64) begin
      capture_in <= 1'b1;
      @(posedge clk_in);
    end
    capture_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    rd(4'h0, 8'h81);
    rd(4'h2, 8'h80);
    chk("full", 8'h01, {7'h0, trace_full_out});
    chk("irq", 8'h01, {7'h0, irq_out});
    rd(4'h3, 8'h05);
    wr(4'h4, 8'h07);
    chk("irq", 8'h00, {7'h0, irq_out});
    rd(4'h3, 8'h00);
    sys_reset_in <= 1'b1;
    @(posedge clk_in);
    sys_reset_in <= 1'b0;
    @(posedge clk_in);
    rd(4'h0, 8'h80);
    wr(4'h1, 8'h80);
    rd(4'h0, 8'h01);
    adv(3'h2);
    end_event_in <= 1'b1;
    @(posedge clk_in);
    end_event_in <= 1'b0;
    @(posedge clk_in);
    rd(4'h0, 8'h00);
    rd(4'h3, 8'h06);
    rd(4'hf, 8'h00);
    final_report;
  end
endmodule
